// File: src/reg_cell_pkg.sv
package reg_cell_pkg;
  // ==========================================================
  // Geometry
  localparam int NUM_CELLS     = 10;
  localparam int REGS_PER_CELL = 2;
  localparam int NUM_REGS      = NUM_CELLS * REGS_PER_CELL;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS                = 10;
  localparam int POWER_UP_CLEAR_INTERVAL_NS   = 1000;
  localparam int POWER_UP_CLEAR_CYCLES        =
    (POWER_UP_CLEAR_INTERVAL_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (POWER_UP_CLEAR_INTERVAL_NS / CLK_PERIOD_NS);
  localparam int CLEAR_CNT_W                  = 8;

  // ==========================================================
  // Reset and encodings
  localparam logic FF_RESET_VAL  = 1'b0;
  localparam logic FF_PRESET_VAL = 1'b1;
  localparam logic TYPE_D        = 1'b0;
  localparam logic TYPE_T        = 1'b1;
  localparam logic CLK_SRC_TERM  = 1'b0;
  localparam logic CLK_SRC_PIN   = 1'b1;
  localparam logic SEL_REG0      = 1'b0;
  localparam logic SEL_REG1      = 1'b1;
  localparam int   REG0_IDX      = 0;
  localparam int   REG1_IDX      = 1;

  typedef enum logic [1:0] {
    ST_CLEAR,
    ST_RUN
  } pwr_state_t;
endpackage

// File: src/cell_ff.sv
`timescale 1ns/1ps
// ==========================================================
// One configurable register of an output logic cell
module cell_ff (
  input  wire logic i_mclk,
  input  wire logic i_clear,
  input  wire logic i_clk_edge,
  input  wire logic i_async_rst,
  input  wire logic i_preset,
  input  wire logic i_is_t,
  input  wire logic i_preload,
  input  wire logic i_load_this,
  input  wire logic i_load_val,
  input  wire logic i_sum,
  output logic      o_q
);
  logic q_r;
  logic q_nxt;
  logic dt_val;

  // ==========================================================
  // Next value
  assign dt_val = i_is_t ? (q_r ^ i_sum) : i_sum;                            // [R04] [R19]
  assign q_nxt  = i_clear     ? reg_cell_pkg::FF_RESET_VAL :                 // [R01]
                  i_async_rst ? reg_cell_pkg::FF_RESET_VAL :                 // [R13] [R14] [R20]
                  i_preload   ? (i_load_this ? i_load_val : q_r) :           // [R15] [R17]
                  !i_clk_edge ? q_r :                                        // [R12]
                  i_preset    ? reg_cell_pkg::FF_PRESET_VAL :                // [R11]
                  dt_val;

  always_ff @(posedge i_mclk) begin
    q_r <= q_nxt;
  end

  assign o_q = q_r;
endmodule

// File: src/reg_output_cells.sv
`timescale 1ns/1ps
// Contract
// R01: After power-up every flip-flop clears to zero; pin level follows polarity.
// R02: Board meets setup before raising clocks after power-up clear.
// R03: Board holds clock sources steady during clear interval, at most 1000 ns.
// R04: Each flip-flop chosen D-type or T-type individually.
// R05: Each flip-flop clocked by own term or by the clock pin.
// R06: Two flip-flops per cell, twenty in total.
// R07: Each register has its own sum, reset and clock term.
// R08: Every I/O pin has an input path regardless of its driver.
// R09: Each register feeds its state back to the array separately.
// R10: Each output driver has its own enable term.
// R11: One synchronous preset sets all registers high instead of loading.
// R12: Preset acts only on a rising clock edge; board raises clocks.
// R13: Each flip-flop has its own asynchronous reset clearing it.
// R14: Reset clears both master and slave stage.
// R15: In preload, pin high loads one, low loads zero, ignoring polarity.
// R16: Preload entered only while preload input asserted by board.
// R17: Preload clock pulse loads register zero or one per select pin.
// R18: Compatibility mode: no T-type, no pin clocking, no second feedback.
// R19: T-type inverts on clock edge when sum true, else holds.
// R20: Asynchronous reset beats preset and any clocked load.
module reg_output_cells #(
  parameter int NUM_CELLS = reg_cell_pkg::NUM_CELLS,
  parameter int NUM_REGS  = reg_cell_pkg::NUM_REGS
) (
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst,
  input  wire logic                 i_clk_pin,
  input  wire logic [NUM_REGS-1:0]  i_clk_term,
  input  wire logic [NUM_REGS-1:0]  i_sum_term,
  input  wire logic [NUM_REGS-1:0]  i_async_rst_term,
  input  wire logic                 i_sync_preset,
  input  wire logic [NUM_REGS-1:0]  i_cfg_t_type,
  input  wire logic [NUM_REGS-1:0]  i_cfg_pin_clk,
  input  wire logic [NUM_CELLS-1:0] i_cfg_out_pol,
  input  wire logic                 i_cfg_compat,
  input  wire logic [NUM_CELLS-1:0] i_oe_term,
  input  wire logic                 i_preload_mode,
  input  wire logic                 i_preload_sel,
  input  wire logic [NUM_CELLS-1:0] i_io_in,
  output logic      [NUM_CELLS-1:0] o_io_out,
  output logic      [NUM_CELLS-1:0] o_io_oe,
  output logic      [NUM_CELLS-1:0] o_io_in_path,
  output logic      [NUM_REGS-1:0]  o_feedback,
  output logic                      o_clear_busy
);
  localparam int R0 = reg_cell_pkg::REG0_IDX;
  localparam int R1 = reg_cell_pkg::REG1_IDX;
  localparam int RPC = reg_cell_pkg::REGS_PER_CELL;

  reg_cell_pkg::pwr_state_t              state_r;
  reg_cell_pkg::pwr_state_t              state_nxt;
  logic [reg_cell_pkg::CLEAR_CNT_W-1:0]  clear_cnt_r;
  logic [reg_cell_pkg::CLEAR_CNT_W-1:0]  clear_cnt_nxt;
  logic                                  clearing;
  logic                                  clk_pin_r;
  logic [NUM_REGS-1:0]                   clk_term_r;
  logic                                  pin_rise;
  logic [NUM_REGS-1:0]                   term_rise;
  logic [NUM_REGS-1:0]                   ff_q;
  logic [NUM_REGS-1:0]                   fb_nxt;
  logic [NUM_CELLS-1:0]                  out_nxt;
  logic [NUM_CELLS-1:0]                  oe_r;
  logic [NUM_CELLS-1:0]                  out_r;
  logic [NUM_CELLS-1:0]                  in_path_r;
  logic [NUM_REGS-1:0]                   fb_r;
  logic                                  busy_r;

  // ==========================================================
  // Power-up clear sequencer
  localparam logic [reg_cell_pkg::CLEAR_CNT_W-1:0] CLEAR_LAST =
    reg_cell_pkg::CLEAR_CNT_W'(reg_cell_pkg::POWER_UP_CLEAR_CYCLES - 1);
  localparam logic [reg_cell_pkg::CLEAR_CNT_W-1:0] CNT_ONE =
    reg_cell_pkg::CLEAR_CNT_W'(1);

  assign clearing      = (state_r == reg_cell_pkg::ST_CLEAR);
  assign clear_cnt_nxt = clearing ? clear_cnt_r + CNT_ONE : clear_cnt_r;
  assign state_nxt     = (clearing && clear_cnt_r == CLEAR_LAST) ?
                         reg_cell_pkg::ST_RUN : state_r;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_r     <= reg_cell_pkg::ST_CLEAR;
      clear_cnt_r <= '0;
    end else begin
      state_r     <= state_nxt;                                              // [R01] [R03]
      clear_cnt_r <= clear_cnt_nxt;
    end
  end

  // ==========================================================
  // Clock source edge detection
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      clk_pin_r  <= 1'b0;
      clk_term_r <= '0;
    end else begin
      clk_pin_r  <= i_clk_pin;
      clk_term_r <= i_clk_term;
    end
  end

  // Edges before clear ends are discarded; board keeps clocks steady
  assign pin_rise  = i_clk_pin & ~clk_pin_r & ~clearing;                     // [R02] [R03]
  assign term_rise = i_clk_term & ~clk_term_r & {NUM_REGS{~clearing}};

  // ==========================================================
  // Register array
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_ff                              // [R06]
      logic use_pin;
      logic use_t;
      logic edge_sel;
      logic load_this;
      assign use_pin   = i_cfg_pin_clk[g] & ~i_cfg_compat;                   // [R05] [R18]
      assign use_t     = i_cfg_t_type[g] & ~i_cfg_compat;                    // [R04] [R18]
      assign edge_sel  = use_pin ? pin_rise : term_rise[g];                  // [R05] [R07]
      assign load_this = term_rise[g] &
                         (i_preload_sel == ((g % RPC == R1) ?
                          reg_cell_pkg::SEL_REG1 : reg_cell_pkg::SEL_REG0)); // [R17]

      cell_ff u_ff (
        .i_mclk      (i_mclk),
        .i_clear     (clearing | i_rst),
        .i_clk_edge  (edge_sel),
        .i_async_rst (i_async_rst_term[g]),                                  // [R13]
        .i_preset    (i_sync_preset),                                        // [R11]
        .i_is_t      (use_t),
        .i_preload   (i_preload_mode),                                       // [R16]
        .i_load_this (load_this),
        .i_load_val  (i_io_in[g / RPC]),                                     // [R15]
        .i_sum       (i_sum_term[g]),                                        // [R07]
        .o_q         (ff_q[g])
      );

      // Second register feedback is absent in compatibility mode
      if (g % RPC == R1) begin : g_fb1
        assign fb_nxt[g] = ff_q[g] & ~i_cfg_compat;                          // [R09] [R18]
      end else begin : g_fb0
        assign fb_nxt[g] = ff_q[g];                                          // [R09]
      end
    end
  endgenerate

  // ==========================================================
  // Output cells
  genvar c;
  generate
    for (c = 0; c < NUM_CELLS; c++) begin : g_cell
      assign out_nxt[c] = ff_q[c * RPC + R0] ^ i_cfg_out_pol[c];             // [R01]
    end
  endgenerate

  // ==========================================================
  // Registered outputs
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      out_r     <= '0;
      oe_r      <= '0;
      in_path_r <= '0;
      fb_r      <= '0;
      busy_r    <= 1'b1;
    end else begin
      out_r     <= out_nxt;
      oe_r      <= i_oe_term & ~{NUM_CELLS{i_preload_mode}};                 // [R10] [R15]
      in_path_r <= i_io_in;                                                  // [R08]
      fb_r      <= fb_nxt;                                                   // [R09]
      busy_r    <= clearing;
    end
  end

  assign o_io_out     = out_r;
  assign o_io_oe      = oe_r;
  assign o_io_in_path = in_path_r;
  assign o_feedback   = fb_r;
  assign o_clear_busy = busy_r;
endmodule

// File: verif/reg_output_cells_chk.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker
module reg_output_cells_chk #(
  parameter int NUM_CELLS = 10,
  parameter int NUM_REGS  = 20
) (
  input wire logic                 i_mclk,
  input wire logic                 i_rst,
  input wire logic [NUM_REGS-1:0]  i_clk_term,
  input wire logic [NUM_REGS-1:0]  i_sum_term,
  input wire logic [NUM_REGS-1:0]  i_async_rst_term,
  input wire logic                 i_sync_preset,
  input wire logic [NUM_REGS-1:0]  i_cfg_t_type,
  input wire logic [NUM_REGS-1:0]  i_cfg_pin_clk,
  input wire logic                 i_cfg_compat,
  input wire logic [NUM_CELLS-1:0] i_oe_term,
  input wire logic                 i_preload_mode,
  input wire logic [NUM_CELLS-1:0] i_io_in,
  input wire logic [NUM_CELLS-1:0] o_io_oe,
  input wire logic [NUM_CELLS-1:0] o_io_in_path,
  input wire logic [NUM_REGS-1:0]  o_feedback,
  input wire logic                 o_clear_busy
);
  logic [NUM_REGS-1:0] term_q;
  logic [NUM_REGS-1:0] rise;
  logic [NUM_REGS-1:0] d_rise;
  logic                quiet;
  always_ff @(posedge i_mclk) term_q <= i_clk_term;
  assign rise   = i_clk_term & ~term_q & ~i_async_rst_term & ~i_cfg_pin_clk;
  assign d_rise = rise & ~i_cfg_t_type;
  assign quiet  = !i_preload_mode && !o_clear_busy && !i_cfg_compat;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence clear_run;
    ##95 o_clear_busy ##[1:10] !o_clear_busy;
  endsequence
  busy_on_rst_a: assert property (disable iff (1'b0) i_rst |=> o_clear_busy)
    else $error("clear not busy after reset");
  clear_zero_a: assert property (o_clear_busy |-> o_feedback == '0)
    else $error("register set while clearing");
  clear_len_a: assert property ($fell(i_rst) |-> clear_run)
    else $error("clear interval wrong length");
  oe_gate_a: assert property (!$past(i_rst) |->
    o_io_oe == ($past(i_oe_term) & ~{NUM_CELLS{$past(i_preload_mode)}}))
    else $error("output enable wrong");
  in_path_a: assert property (!$past(i_rst) |-> o_io_in_path == $past(i_io_in))
    else $error("input path wrong");
  async_clear_a: assert property (|i_async_rst_term |->
    ##2 (o_feedback & $past(i_async_rst_term, 2)) == '0)
    else $error("async reset did not clear");
  preset_set_a: assert property (i_sync_preset && quiet |->
    ##2 (o_feedback & $past(rise, 2)) == $past(rise, 2))
    else $error("preset did not set");
  d_load_a: assert property (!i_sync_preset && quiet |->
    ##2 ((o_feedback ^ $past(i_sum_term, 2)) & $past(d_rise, 2)) == '0)
    else $error("d load wrong");
endmodule

// File: verif/board_model.sv
`timescale 1ns/1ps
// ==========================================================
// Board clock sources, held low while the device clears
module board_model (
  input  wire logic                              i_mclk,
  input  wire logic                              i_busy,
  input  wire logic [reg_cell_pkg::NUM_REGS-1:0] i_fire,
  input  wire logic                              i_pin_fire,
  output logic      [reg_cell_pkg::NUM_REGS-1:0] o_clk_term,
  output logic                                   o_clk_pin
);
  initial begin
    o_clk_term = '0;
    o_clk_pin  = 1'b0;
  end
  always @(negedge i_mclk) begin
    o_clk_term <= i_busy ? '0 : i_fire;
    o_clk_pin  <= i_busy ? 1'b0 : i_pin_fire;
  end
endmodule

// File: verif/test_reg_output_cells.sv
`timescale 1ns/1ps
// ==========================================================
// Bench
module test_reg_output_cells;
  localparam int NR = reg_cell_pkg::NUM_REGS;
  localparam int NC = reg_cell_pkg::NUM_CELLS;
  logic          i_mclk, i_rst, i_clk_pin, i_sync_preset, i_cfg_compat, pin_fire;
  logic          i_preload_mode, i_preload_sel, o_clear_busy;
  logic [NR-1:0] i_clk_term, i_sum_term, i_async_rst_term, i_cfg_t_type, i_cfg_pin_clk;
  logic [NR-1:0] fire, o_feedback, ex;
  logic [NC-1:0] i_cfg_out_pol, i_oe_term, i_io_in, o_io_out, o_io_oe, o_io_in_path;
  int            error_cnt, n_tests, k;
  reg_output_cells i_dut (.i_mclk, .i_rst, .i_clk_pin, .i_clk_term, .i_sum_term,
    .i_async_rst_term, .i_sync_preset, .i_cfg_t_type, .i_cfg_pin_clk, .i_cfg_out_pol,
    .i_cfg_compat, .i_oe_term, .i_preload_mode, .i_preload_sel, .i_io_in, .o_io_out,
    .o_io_oe, .o_io_in_path, .o_feedback, .o_clear_busy);
  board_model i_board (.i_mclk, .i_busy(o_clear_busy), .i_fire(fire),
    .i_pin_fire(pin_fire), .o_clk_term(i_clk_term), .o_clk_pin(i_clk_pin));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [NR-1:0] got, input logic [NR-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One clock source pulse, then settle
  task automatic pulse(input logic [NR-1:0] t, input logic p);
    @(negedge i_mclk);
    fire     <= t;
    pin_fire <= p;
    @(negedge i_mclk);
    fire     <= '0;
    pin_fire <= 1'b0;
    repeat (4) @(negedge i_mclk);
  endtask
  function automatic logic [NR-1:0] spread(input logic [NC-1:0] v, input int odd);
    spread = '0;
    for (int c = 0; c < NC; c++) spread[2*c+odd] = v[c];
  endfunction
  task automatic results;
    $display("compares %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {i_rst, fire, pin_fire, i_sum_term, i_async_rst_term, i_sync_preset} = {1'b1, 62'h0};
    {i_cfg_t_type, i_cfg_pin_clk, i_cfg_compat, i_preload_mode, i_preload_sel} = '0;
    {i_oe_term, i_io_in, i_cfg_out_pol} = {10'h3C9, 10'h2B5, 10'h155};
    {error_cnt, n_tests} = '0;
    repeat (6) @(negedge i_mclk);
    chk(NR'(o_clear_busy), 20'h00001);
    i_rst = 1'b0;
    for (k = 0; k < 200 && o_clear_busy !== 1'b0; k++) @(negedge i_mclk);
    if (k == 200) begin
      error_cnt++;
      results();
    end
    chk(o_feedback, 20'h00000);
    chk(NR'(o_io_out), NR'(i_cfg_out_pol));
    chk(NR'(o_io_oe), NR'(i_oe_term));
    chk(NR'(o_io_in_path), NR'(i_io_in));
    $display("power-up test end");
    i_sum_term = 20'hA5C3F;
    pulse('1, 1'b0);
    chk(o_feedback, 20'hA5C3F);
    {i_sum_term, i_sync_preset, i_async_rst_term} = {20'h0, 1'b1, 20'h0F0F0};
    pulse('1, 1'b0);
    chk(o_feedback, 20'hF0F0F);
    {i_sync_preset, i_async_rst_term} = {1'b0, 20'h00300};
    repeat (3) @(negedge i_mclk);
    chk(o_feedback, 20'hF0C0F);
    {i_async_rst_term, i_cfg_t_type, i_sum_term} = {20'h0, 20'h0000F, 20'h00005};
    pulse('1, 1'b0);
    chk(o_feedback, 20'h0000A);
    {i_cfg_t_type, i_cfg_pin_clk, i_sum_term} = {20'h0, 20'h00003, 20'hFFFFF};
    pulse('0, 1'b1);
    chk(o_feedback, 20'h0000B);
    $display("register test end");
    {i_cfg_compat, i_cfg_t_type, i_cfg_pin_clk} = {1'b1, 40'hFFFFF_FFFFF};
    pulse('1, 1'b1);
    chk(o_feedback, 20'h55555);
    i_sum_term = '0;
    pulse('0, 1'b1);
    chk(o_feedback, 20'h55555);
    {i_cfg_compat, i_cfg_t_type, i_cfg_pin_clk, i_preload_mode} = {41'h0, 1'b1};
    pulse('1, 1'b0);
    ex = spread(10'h2B5, 0) | spread(10'h3FF, 1);
    chk(o_feedback, ex);
    chk(NR'(o_io_out), NR'(i_io_in ^ i_cfg_out_pol));
    chk(NR'(o_io_oe), 20'h00000);
    {i_preload_sel, i_io_in} = {1'b1, 10'h0F3};
    pulse('1, 1'b0);
    chk(o_feedback, spread(10'h2B5, 0) | spread(10'h0F3, 1));
    $display("compat and preload test end");
    results();
  end
endmodule
bind reg_output_cells reg_output_cells_chk #(.NUM_CELLS(NUM_CELLS), .NUM_REGS(NUM_REGS))
  i_chk (.i_mclk, .i_rst, .i_clk_term, .i_sum_term, .i_async_rst_term, .i_sync_preset,
  .i_cfg_t_type, .i_cfg_pin_clk, .i_cfg_compat, .i_oe_term, .i_preload_mode, .i_io_in,
  .o_io_oe, .o_io_in_path, .o_feedback, .o_clear_busy);
